// *** rtl/phyctl_pkg.sv ***
// Package with the control register layout, reset value and serial frame constants.
package phyctl_pkg;

    // Register address and reset value.
    localparam logic [4:0] PHYCTL_ADDR_CONTROL = 5'h00;
    localparam logic [15:0] PHYCTL_CONTROL_RST = 16'h3100;

    // Field positions inside the control register.
    localparam int PHYCTL_BIT_SOFT_RESET = 15;
    localparam int PHYCTL_BIT_LOOP_BACK = 14;
    localparam int PHYCTL_BIT_RATE = 13;
    localparam int PHYCTL_BIT_NEG_EN = 12;
    localparam int PHYCTL_BIT_LOW_POWER = 11;
    localparam int PHYCTL_BIT_ISOLATE = 10;
    localparam int PHYCTL_BIT_RESTART = 9;
    localparam int PHYCTL_BIT_DUPLEX = 8;
    localparam int PHYCTL_BIT_COL_TEST = 7;
    localparam logic [15:0] PHYCTL_WRITABLE_MASK = 16'hFF80;

    // Serial management frame figures.
    localparam logic [5:0] PHYCTL_PREAMBLE_LEN = 6'h20;
    localparam logic [5:0] PHYCTL_HDR_LAST = 6'h0C;
    localparam logic [5:0] PHYCTL_TA_LAST = 6'h01;
    localparam logic [5:0] PHYCTL_DATA_LAST = 6'h0F;
    localparam logic [1:0] PHYCTL_OP_READ = 2'h2;
    localparam logic [1:0] PHYCTL_OP_WRITE = 2'h1;
    localparam logic [4:0] PHYCTL_PHY_ADDR_DEF = 5'h00;

    typedef enum logic [3:0] {
        PHYCTL_ST_IDLE = 4'h1,
        PHYCTL_ST_HDR = 4'h2,
        PHYCTL_ST_TA = 4'h4,
        PHYCTL_ST_DATA = 4'h8
    } phyctl_state_e;

    // Control fields as seen by the rest of the PHY.
    typedef struct packed {
        logic soft_reset;
        logic loop_back_enable;
        logic rate_select;
        logic negotiation_enable;
        logic low_power_enable;
        logic isolate;
        logic restart_negotiation;
        logic duplex_full;
        logic collision_test_enable;
    } phyctl_ctrl_s;

endpackage : phyctl_pkg

// *** rtl/phyctl_top.sv ***
// Control register of the PHY with its serial management slave.
// What this block does
// - The control register answers at management address 0x00 and resets to 0x3100.
// - The duplex bit selects full duplex at 1 and half at 0, is set by software or negotiation.
// - Setting the collision test bit 7 enables collision test mode; it resets to 0.
// - While collision test is on, the collision indication is set when a transmission starts and cleared when it halts.
// - The register is reached by serial management frames with 16-bit data on a divided clock.
module phyctl_top #(
    parameter logic [4:0] PHY_ADDR = phyctl_pkg::PHYCTL_PHY_ADDR_DEF
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial management pins.
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    // PHY core events, same clock.
    input wire logic tx_start,
    input wire logic tx_halt,
    input wire logic neg_restart_done,
    input wire logic neg_result_valid,
    input wire logic neg_result_full,
    // Control outputs.
    output phyctl_pkg::phyctl_ctrl_s ctrl,
    output logic soft_reset_pulse,
    output logic collision_active
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] mdc_sync_q;
    logic [1:0] mdio_sync_q;
    logic mdc_prev_q;
    logic mdc_rise;
    phyctl_pkg::phyctl_state_e state_q;
    logic [5:0] pre_cnt_q;
    logic [5:0] cnt_q;
    logic [11:0] hdr_q;
    logic [12:0] hdr_word;
    logic hit_q;
    logic read_q;
    logic reg_hit_q;
    logic [15:0] wdata_q;
    logic [15:0] rd_shift_q;
    logic wr_commit_q;
    logic [15:0] control_q;
    logic col_q;
    logic pulse_q;
    logic out_q;
    logic oe_n_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Management pins are asynchronous to the system clock.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mdc_sync_q <= 2'h0;
            mdio_sync_q <= 2'h0;
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_sync_q <= {mdc_sync_q[0], mdc};
            mdio_sync_q <= {mdio_sync_q[0], mdio_in};
            mdc_prev_q <= mdc_sync_q[1];
        end
    end
    assign mdc_rise = mdc_sync_q[1] & ~mdc_prev_q;
    assign hdr_word = {hdr_q, mdio_sync_q[1]};

    // Frame decoder: preamble, start, opcode, addresses, turnaround, 16 data bits.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
            pre_cnt_q <= 6'h00;
            cnt_q <= 6'h00;
            hdr_q <= 12'h000;
            hit_q <= 1'b0;
            read_q <= 1'b0;
            reg_hit_q <= 1'b0;
            wdata_q <= 16'h0000;
            wr_commit_q <= 1'b0;
        end else begin
            wr_commit_q <= 1'b0;
            if (mdc_rise) begin
                case (state_q)
                    phyctl_pkg::PHYCTL_ST_IDLE: begin
                        if (mdio_sync_q[1]) begin
                            if (pre_cnt_q != phyctl_pkg::PHYCTL_PREAMBLE_LEN) begin
                                pre_cnt_q <= pre_cnt_q + 6'h01;
                            end
                        end else begin
                            if (pre_cnt_q == phyctl_pkg::PHYCTL_PREAMBLE_LEN) begin
                                state_q <= phyctl_pkg::PHYCTL_ST_HDR;
                            end
                            pre_cnt_q <= 6'h00;
                            cnt_q <= 6'h00;
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_HDR: begin
                        hdr_q <= hdr_word[11:0];
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == phyctl_pkg::PHYCTL_HDR_LAST) begin
                            cnt_q <= 6'h00;
                            read_q <= hdr_word[11:10] == phyctl_pkg::PHYCTL_OP_READ;
                            hit_q <= hdr_word[9:5] == PHY_ADDR;
                            reg_hit_q <= hdr_word[4:0] == phyctl_pkg::PHYCTL_ADDR_CONTROL;
                            if (hdr_word[12] && hdr_word[9:5] == PHY_ADDR &&
                                (hdr_word[11:10] == phyctl_pkg::PHYCTL_OP_READ ||
                                 hdr_word[11:10] == phyctl_pkg::PHYCTL_OP_WRITE)) begin
                                state_q <= phyctl_pkg::PHYCTL_ST_TA;
                            end else begin
                                state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
                            end
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_TA: begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == phyctl_pkg::PHYCTL_TA_LAST) begin
                            cnt_q <= 6'h00;
                            state_q <= phyctl_pkg::PHYCTL_ST_DATA;
                        end
                    end
                    phyctl_pkg::PHYCTL_ST_DATA: begin
                        wdata_q <= {wdata_q[14:0], mdio_sync_q[1]};
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == phyctl_pkg::PHYCTL_DATA_LAST) begin
                            cnt_q <= 6'h00;
                            state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
                            wr_commit_q <= ~read_q & reg_hit_q;
                        end
                    end
                    default: begin
                        state_q <= phyctl_pkg::PHYCTL_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Read data path; undefined addresses read as zero.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift_q <= 16'h0000;
            out_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else if (mdc_rise) begin
            if (state_q == phyctl_pkg::PHYCTL_ST_HDR) begin
                rd_shift_q <= (hdr_word[4:0] == phyctl_pkg::PHYCTL_ADDR_CONTROL) ?
                    control_q : 16'h0000;
            end else if (state_q == phyctl_pkg::PHYCTL_ST_TA && read_q && hit_q) begin
                oe_n_q <= 1'b0;
                if (cnt_q == phyctl_pkg::PHYCTL_TA_LAST) begin
                    out_q <= rd_shift_q[15];
                    rd_shift_q <= {rd_shift_q[14:0], 1'b0};
                end else begin
                    out_q <= 1'b0;
                end
            end else if (state_q == phyctl_pkg::PHYCTL_ST_DATA && read_q && hit_q) begin
                if (cnt_q == phyctl_pkg::PHYCTL_DATA_LAST) begin
                    oe_n_q <= 1'b1;
                    out_q <= 1'b1;
                end else begin
                    out_q <= rd_shift_q[15];
                    rd_shift_q <= {rd_shift_q[14:0], 1'b0};
                end
            end else begin
                oe_n_q <= 1'b1;
                out_q <= 1'b1;
            end
        end
    end

    // Control register; later assignments win, so a write beats a hardware clear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= phyctl_pkg::PHYCTL_CONTROL_RST;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= 1'b0;
            if (control_q[phyctl_pkg::PHYCTL_BIT_SOFT_RESET]) begin
                control_q <= phyctl_pkg::PHYCTL_CONTROL_RST;
                pulse_q <= 1'b1;
            end else begin
                if (neg_restart_done) begin
                    control_q[phyctl_pkg::PHYCTL_BIT_RESTART] <= 1'b0;
                end
                if (neg_result_valid && control_q[phyctl_pkg::PHYCTL_BIT_NEG_EN]) begin
                    control_q[phyctl_pkg::PHYCTL_BIT_DUPLEX] <= neg_result_full;
                end
                if (wr_commit_q) begin
                    control_q <= wdata_q & phyctl_pkg::PHYCTL_WRITABLE_MASK;
                end
            end
        end
    end

    // Collision indication follows transmissions while collision test is on.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= 1'b0;
        end else begin
            if (tx_halt || !control_q[phyctl_pkg::PHYCTL_BIT_COL_TEST]) begin
                col_q <= 1'b0;
            end
            if (tx_start && control_q[phyctl_pkg::PHYCTL_BIT_COL_TEST]) begin
                col_q <= 1'b1;
            end
        end
    end

    assign mdio_out = out_q;
    assign mdio_oe_n = oe_n_q;
    assign soft_reset_pulse = pulse_q;
    assign collision_active = col_q;
    assign ctrl = control_q[15:7];

    sequence seq_read_turn;
        mdc_rise && state_q == phyctl_pkg::PHYCTL_ST_TA && read_q && hit_q;
    endsequence
    sequence seq_write_done;
        wr_commit_q && !control_q[phyctl_pkg::PHYCTL_BIT_SOFT_RESET];
    endsequence

    AST_RESET_VALUE: assert property (@(posedge clk_sys) $rose(rst_n) |->
        control_q == phyctl_pkg::PHYCTL_CONTROL_RST) else $error("bad reset value");
    AST_SOFT_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        control_q[phyctl_pkg::PHYCTL_BIT_SOFT_RESET] |=>
        control_q == phyctl_pkg::PHYCTL_CONTROL_RST && soft_reset_pulse)
        else $error("soft reset not carried out");
    AST_RESTART_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        control_q[phyctl_pkg::PHYCTL_BIT_RESTART] && !neg_restart_done && !wr_commit_q &&
        !control_q[phyctl_pkg::PHYCTL_BIT_SOFT_RESET] |=>
        control_q[phyctl_pkg::PHYCTL_BIT_RESTART])
        else $error("restart cleared early");
    AST_WRITE_TAKES: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seq_write_done |=>
        control_q[phyctl_pkg::PHYCTL_BIT_DUPLEX] ==
        $past(wdata_q[phyctl_pkg::PHYCTL_BIT_DUPLEX]) &&
        control_q[phyctl_pkg::PHYCTL_BIT_COL_TEST] ==
        $past(wdata_q[phyctl_pkg::PHYCTL_BIT_COL_TEST]))
        else $error("write not stored");
    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        control_q[6:0] == 7'h00) else $error("reserved bits not zero");
    AST_COL_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_start && control_q[phyctl_pkg::PHYCTL_BIT_COL_TEST] |=> collision_active)
        else $error("collision not set");
    AST_COL_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_halt && !tx_start ##1 !tx_start [*2] |-> !collision_active)
        else $error("collision not cleared");
    AST_COL_ENABLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !control_q[phyctl_pkg::PHYCTL_BIT_COL_TEST] |=> !collision_active)
        else $error("collision without test mode");
    AST_READ_DRIVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        seq_read_turn |=> !mdio_oe_n) else $error("read not driven at turnaround");

endmodule // phyctl_top

// *** tb/phyctl_station.sv ***
// Management station model that frames serial accesses toward the PHY.
module phyctl_station (
    // Clock.
    input wire logic clk_sys,
    // Pins toward the PHY.
    output logic mdc,
    output logic mdio_line,
    input wire logic mdio_out,
    input wire logic mdio_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_en = 1'b0;
    logic drv_bit = 1'b1;
    // The line has a pull-up, so it reads 1 when nobody drives it.
    assign mdio_line = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);
    initial mdc = 1'b0;
    // One bit slot: low half, then a rising edge, with the line sampled just before it.
    task automatic slot(input logic en, input logic b, output logic seen);
        @(posedge clk_sys);
        mdc <= 1'b0;
        drv_en <= en;
        drv_bit <= b;
        repeat (5) @(posedge clk_sys);
        seen = mdio_line;
        mdc <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic rd;
        logic s;
        hdr = {2'b01, op, phy, ra};
        rd = (op == phyctl_pkg::PHYCTL_OP_READ);
        rdata = 16'h0000;
        if (!rd && ra != phyctl_pkg::PHYCTL_ADDR_CONTROL) return;
        repeat (32) slot(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
        slot(!rd, 1'b1, s);
        slot(!rd, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            slot(!rd, wdata[i] & phyctl_pkg::PHYCTL_WRITABLE_MASK[i], s);
            rdata[i] = s;
        end
        slot(1'b0, 1'b1, s);
    endtask
endmodule // phyctl_station

// *** tb/testbench.sv ***
// Self-checking bench for the PHY control register and its serial access.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] ev = 4'h0;
    logic full = 1'b1;
    logic mdc, mdio_in, mdio_out, mdio_oe_n, soft_reset_pulse, collision_active;
    phyctl_pkg::phyctl_ctrl_s ctrl;
    logic [15:0] rd;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int pulses = 0;
    always #2.5 clk_sys = ~clk_sys;
    phyctl_top u_phyctl_top (.clk_sys(clk_sys), .reset_n(reset_n), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .tx_start(ev[0]),
        .tx_halt(ev[1]), .neg_restart_done(ev[2]), .neg_result_valid(ev[3]),
        .neg_result_full(full), .ctrl(ctrl), .soft_reset_pulse(soft_reset_pulse),
        .collision_active(collision_active));
    phyctl_station u_phyctl_station (.clk_sys(clk_sys), .mdc(mdc), .mdio_line(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] phy, input logic [15:0] d);
        u_phyctl_station.frame(phyctl_pkg::PHYCTL_OP_WRITE, phy, 5'h00, d, rd);
    endtask
    task automatic rdchk(input logic [15:0] exp);
        u_phyctl_station.frame(phyctl_pkg::PHYCTL_OP_READ, 5'h00, 5'h00, 16'h0000, rd);
        chk16("read word", exp, rd);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        ev[k] <= 1'b1;
        @(posedge clk_sys);
        ev <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk16("ctrl", 16'h3100, {ctrl, 7'h00});
        chk1("mdio_oe_n", 1'b1, mdio_oe_n);
        rdchk(16'h3100);
        wr(5'h00, 16'h1200);
        chk1("duplex", 1'b0, ctrl.duplex_full);
        rdchk(16'h1200);
        pulse(2);
        rdchk(16'h1000);
        pulse(3);
        rdchk(16'h1100);
        wr(5'h00, 16'h0080);
        rdchk(16'h0080);
        pulse(0);
        chk1("collision", 1'b1, collision_active);
        pulse(1);
        chk1("collision", 1'b0, collision_active);
        wr(5'h01, 16'h0000);
        rdchk(16'h0080);
        wr(5'h00, 16'h8000);
        chk16("ctrl", 16'h3100, {ctrl, 7'h00});
        chk16("reset pulses", 16'h0001, 16'(pulses));
        rdchk(16'h3100);
        give_verdict();
    end
endmodule // testbench
